// ### common/osw_pkg.sv
// Shared constants and types for the octal switch serial control block
package osw_pkg;
  localparam int NCH = 8;
  localparam int FRAME_BITS = 16;
  localparam int CLK_MHZ = 250;
  // Fault filter and overload switch-off delay, in microseconds
  localparam int FAULT_FILTER_US = 200;
  localparam int OL_DELAY_US = 100;
  localparam int FAULT_FILTER_CYC = FAULT_FILTER_US * CLK_MHZ;
  localparam int OL_DELAY_CYC = OL_DELAY_US * CLK_MHZ;

  // Register addresses
  localparam logic [2:0] ADDR_MAP = 3'h1;
  localparam logic [2:0] ADDR_BOL = 3'h2;
  localparam logic [2:0] ADDR_OVL = 3'h3;
  localparam logic [2:0] ADDR_OVT = 3'h4;
  localparam logic [2:0] ADDR_SLE = 3'h5;
  localparam logic [2:0] ADDR_STA = 3'h6;
  localparam logic [2:0] ADDR_CTL = 3'h7;

  // Values after reset, and the prefix of a read answer
  localparam logic [7:0] MAP_RST = 8'h08;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [4:0] READ_PREFIX = 5'h08;

  // Two-bit diagnosis codes per channel (H = 1)
  localparam logic [1:0] DG_OK = 2'h3;
  localparam logic [1:0] DG_OVER = 2'h2;
  localparam logic [1:0] DG_OPEN = 2'h1;
  localparam logic [1:0] DG_SHORT = 2'h0;

  typedef enum logic [1:0] {
    CMD_DIAG = 2'b00,
    CMD_READ = 2'b01,
    CMD_RESET = 2'b10,
    CMD_WRITE = 2'b11
  } osw_cmd_t;

  typedef struct packed {
    osw_cmd_t cmd;
    logic [2:0] spare;
    logic [2:0] addr;
    logic [7:0] data;
  } osw_frame_t;

  // Per-channel sensor flags from the analog stages
  typedef struct packed {
    logic [NCH-1:0] over_temp;
    logic [NCH-1:0] cur_limit;
    logic [NCH-1:0] open_load;
    logic [NCH-1:0] short_gnd;
  } osw_sense_t;
endpackage

// ### rtl/osw_spi_shift.sv
// Serial shift register, edge detection and frame bit counter
`timescale 1ns/1ps
`default_nettype none
module osw_spi_shift import osw_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Synchronised link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  // Control
  input wire logic sleep,
  input wire logic [FRAME_BITS-1:0] load_word,
  // Frame results
  output logic cs_fall,
  output logic frame_end,
  output logic frame_ok,
  output osw_frame_t frame,
  // Serial output pin
  output logic so,
  output logic so_oe
);
  logic cs_q;
  logic sclk_q;
  logic [FRAME_BITS-1:0] shift;
  logic [2:0] bit_cnt;
  logic any_clk;
  logic cs_fall_w;
  logic cs_rise_w;
  logic sclk_fall_w;
  logic sclk_rise_w;

  assign cs_fall_w = cs_q & ~cs_n;
  assign cs_rise_w = ~cs_q & cs_n;
  // Clock edges count only while selected
  assign sclk_fall_w = sclk_q & ~sclk & ~cs_n & ~cs_q;
  assign sclk_rise_w = ~sclk_q & sclk & ~cs_n & ~cs_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_q <= cs_n;
      sclk_q <= sclk;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || sleep) begin
      shift <= '0;
    end else if (cs_fall_w) begin
      shift <= load_word;
    end else if (sclk_fall_w) begin
      shift <= {shift[FRAME_BITS-2:0], si};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || cs_fall_w) begin
      bit_cnt <= 3'h0;
      any_clk <= 1'b0;
    end else if (sclk_fall_w) begin
      bit_cnt <= bit_cnt + 3'h1;
      any_clk <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || cs_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (cs_fall_w) begin
      so <= sleep ? 1'b0 : load_word[FRAME_BITS-1];
      so_oe <= 1'b1;
    end else if (sclk_rise_w) begin
      so <= shift[FRAME_BITS-1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cs_fall <= 1'b0;
      frame_end <= 1'b0;
      frame_ok <= 1'b0;
      frame <= '0;
    end else begin
      cs_fall <= cs_fall_w;
      frame_end <= cs_rise_w;
      frame_ok <= any_clk && bit_cnt == 3'h0 && !sleep;
      frame <= shift;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_so_hiz;
    cs_n |=> !so_oe;
  endproperty
  a_so_hiz: assert property (p_so_hiz) else $error("SO driven while deselected");

  sequence s_select;
    cs_q && !cs_n && !sleep;
  endsequence
  property p_diag_load;
    s_select |=> so_oe && so == $past(load_word[FRAME_BITS-1]);
  endproperty
  a_diag_load: assert property (p_diag_load) else $error("First SO bit not loaded");
endmodule
`default_nettype wire

// ### rtl/osw_switch_ctrl.sv
// Octal low-side switch: serial control, channel logic, protection and diagnosis
`timescale 1ns/1ps
`default_nettype none
module osw_switch_ctrl import osw_pkg::*; #(
  parameter int FILT_CYC = FAULT_FILTER_CYC,
  parameter int OL_CYC = OL_DELAY_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Serial link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Mode and parallel control pins
  input wire logic rst_pin_n,
  input wire logic polarity_select_pin,
  input wire logic [2:0] fixed_parallel_inputs,
  input wire logic mappable_parallel_input,
  // Analog sensor flags
  input wire osw_sense_t sense,
  // Channel drive
  output logic [NCH-1:0] chan_on,
  output logic [NCH-1:0] slew_slow,
  // Open-drain fault pin
  output logic fault_out,
  output logic fault_oe
);
  localparam int CNT_MAX = (FILT_CYC > OL_CYC) ? FILT_CYC : OL_CYC;
  localparam int CW = $clog2(CNT_MAX + 1);
  localparam int SYNC_W = 3 + 1 + 1 + 3 + 1 + $bits(osw_sense_t);

  // Every pin input crosses into core_clk through two flops
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic s_cs_n;
  logic s_sclk;
  logic s_si;
  logic s_rst_n;
  logic s_pol;
  logic [2:0] s_fixed;
  logic s_map_in;
  osw_sense_t s_sense;

  always_ff @(posedge core_clk) begin
    sync1 <= {cs_n, sclk, si, rst_pin_n, polarity_select_pin, fixed_parallel_inputs,
              mappable_parallel_input, sense};
    sync2 <= sync1;
  end

  assign {s_cs_n, s_sclk, s_si, s_rst_n, s_pol, s_fixed, s_map_in, s_sense} = sync2;

  logic sleep;
  assign sleep = ~s_rst_n;

  // Configuration registers
  logic [NCH-1:0] map;
  logic [NCH-1:0] bol;
  logic [NCH-1:0] ovl;
  logic [NCH-1:0] ovt;
  logic [NCH-1:0] sle;
  logic [NCH-1:0] ctl;

  // Serial interface
  logic cs_fall;
  logic frame_end;
  logic frame_ok;
  osw_frame_t frame;
  logic [FRAME_BITS-1:0] load_word;
  logic [FRAME_BITS-1:0] diag_word;
  logic rd_pend;
  logic [FRAME_BITS-1:0] rd_word;
  logic accept;
  logic do_write;
  logic do_reset;
  logic diag_clr;

  function automatic logic cmd_valid(input osw_frame_t f);
    logic ok;
    ok = 1'b1;
    unique case (f.cmd)
      CMD_DIAG: ok = 1'b1;
      CMD_RESET: ok = 1'b1;
      CMD_READ: ok = f.addr != 3'h0;
      CMD_WRITE: ok = f.addr != 3'h0 && f.addr != ADDR_STA;
    endcase
    return ok;
  endfunction

  function automatic logic [NCH-1:0] reg_value(input logic [2:0] addr,
      input logic [7*NCH-1:0] regs);
    logic [NCH-1:0] v;
    v = '0;
    if (addr != 3'h0) begin
      v = regs[8*(7-addr) +: 8];
    end
    return v;
  endfunction

  osw_spi_shift u_shift (
    .core_clk (core_clk),
    .srst (srst),
    .cs_n (s_cs_n),
    .sclk (s_sclk),
    .si (s_si),
    .sleep (sleep),
    .load_word (load_word),
    .cs_fall (cs_fall),
    .frame_end (frame_end),
    .frame_ok (frame_ok),
    .frame (frame),
    .so (so),
    .so_oe (so_oe)
  );

  // Bad bit count or bad command leaves everything as it was
  assign accept = frame_end && frame_ok && cmd_valid(frame);
  assign do_write = accept && frame.cmd == CMD_WRITE;
  assign do_reset = accept && frame.cmd == CMD_RESET;
  assign diag_clr = accept;

  assign load_word = rd_pend ? rd_word : diag_word;

  // Read answer goes out in the following frame
  always_ff @(posedge core_clk) begin
    if (srst || sleep) begin
      rd_pend <= 1'b0;
      rd_word <= '0;
    end else if (accept && frame.cmd == CMD_READ) begin
      rd_pend <= 1'b1;
      rd_word <= {READ_PREFIX, frame.addr,
                  reg_value(frame.addr, {map, bol, ovl, ovt, sle, chan_on, ctl})};
    end else if (cs_fall) begin
      rd_pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || sleep || do_reset) begin
      map <= MAP_RST;
      bol <= CFG_RST;
      ovl <= CFG_RST;
      ovt <= CFG_RST;
      sle <= CFG_RST;
      ctl <= CFG_RST;
    end else if (do_write) begin
      unique case (frame.addr)
        ADDR_MAP: map <= frame.data;
        ADDR_BOL: bol <= frame.data;
        ADDR_OVL: ovl <= frame.data;
        ADDR_OVT: ovt <= frame.data;
        ADDR_SLE: sle <= frame.data;
        ADDR_CTL: ctl <= frame.data;
        default: ;
      endcase
    end
  end

  // Parallel sources and per-channel combination
  logic map_act;
  logic [2:0] fixed_act;
  logic [NCH-1:0] par;
  logic [NCH-1:0] eff;
  logic [NCH-1:0] eff_q;
  logic [NCH-1:0] eff_rise;

  assign map_act = s_map_in ~^ s_pol;
  assign fixed_act = s_fixed ~^ {3{s_pol}};
  // Mapped channels take the mappable input in place of their own pin
  assign par = (map & {NCH{map_act}}) | (~map & {5'h00, fixed_act});
  assign eff = (bol & par & ctl) | (~bol & (par | ctl));
  assign eff_rise = eff & ~eff_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      eff_q <= '0;
    end else begin
      eff_q <= eff;
    end
  end

  // Protection latches and fault timers
  logic [NCH-1:0] ot_off;
  logic [NCH-1:0] ol_off;
  logic [CW-1:0] lim_cnt [NCH];
  logic [CW-1:0] flt_cnt [NCH];
  logic [NCH-1:0] ol_trip;
  logic [NCH-1:0] flt_hit;
  logic [NCH-1:0] ot_trip;
  logic [NCH-1:0] flt_cond;
  logic [NCH-1:0] next_on;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ot_trip[i] = chan_on[i] && s_sense.over_temp[i];
      ol_trip[i] = ovl[i] && chan_on[i] && s_sense.cur_limit[i] &&
                   lim_cnt[i] == CW'(OL_CYC - 1);
      flt_cond[i] = chan_on[i] ? s_sense.cur_limit[i]
                               : (s_sense.open_load[i] | s_sense.short_gnd[i]);
      flt_hit[i] = flt_cond[i] && flt_cnt[i] == CW'(FILT_CYC - 1);
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst || sleep || do_reset) begin
        ot_off[i] <= 1'b0;
      end else if (ot_trip[i]) begin
        ot_off[i] <= 1'b1;
      end else if (ot_off[i]) begin
        if (ovt[i]) begin
          ot_off[i] <= ~eff_rise[i];
        end else begin
          // Cooled with input still on restarts; a dropped input also unlocks
          ot_off[i] <= s_sense.over_temp[i] & eff[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst || sleep || do_reset) begin
        ol_off[i] <= 1'b0;
      end else if (ol_trip[i]) begin
        ol_off[i] <= 1'b1;
      end else if (eff_rise[i]) begin
        ol_off[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst || !(chan_on[i] && s_sense.cur_limit[i])) begin
        lim_cnt[i] <= '0;
      end else if (lim_cnt[i] != CW'(OL_CYC - 1)) begin
        lim_cnt[i] <= lim_cnt[i] + CW'(1);
      end
    end
  end

  // Filter restarts whenever a valid frame clears diagnosis
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst || sleep || diag_clr || !flt_cond[i]) begin
        flt_cnt[i] <= '0;
      end else if (flt_cnt[i] != CW'(FILT_CYC - 1)) begin
        flt_cnt[i] <= flt_cnt[i] + CW'(1);
      end
    end
  end

  // Diagnosis register, newest error wins
  logic [1:0] diag [NCH];
  logic [1:0] diag_code [NCH];
  logic [NCH-1:0] diag_set;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      diag_set[i] = ot_trip[i] | ol_trip[i] | flt_hit[i];
      if (ot_trip[i] || ol_trip[i] || (flt_hit[i] && chan_on[i])) begin
        diag_code[i] = DG_OVER;
      end else if (s_sense.short_gnd[i]) begin
        diag_code[i] = DG_SHORT;
      end else begin
        diag_code[i] = DG_OPEN;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst || sleep) begin
        diag[i] <= DG_OK;
      end else if (diag_set[i]) begin
        diag[i] <= diag_code[i];
      end else if (diag_clr) begin
        diag[i] <= DG_OK;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      diag_word[2*i +: 2] = diag[i];
    end
  end

  // Outputs
  assign next_on = eff & ~ot_off & ~ol_off & ~{NCH{sleep}};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      chan_on <= '0;
      slew_slow <= '0;
    end else begin
      chan_on <= next_on;
      slew_slow <= sle;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fault_out <= 1'b0;
      fault_oe <= 1'b0;
    end else begin
      // Open drain: the pin is only ever pulled low
      fault_out <= 1'b0;
      fault_oe <= diag_word != {FRAME_BITS{1'b1}};
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_sleep_off;
    sleep |=> chan_on == '0 && ctl == '0;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("Outputs on during sleep");

  property p_or_on;
    (!sleep && (~bol & ctl & ~ot_off & ~ol_off) != '0) |=>
      (chan_on & $past(~bol & ctl & ~ot_off & ~ol_off)) == $past(~bol & ctl & ~ot_off & ~ol_off);
  endproperty
  a_or_on: assert property (p_or_on) else $error("OR channel not on");

  property p_and_off;
    (bol & ~(par & ctl)) != '0 |=> (chan_on & $past(bol & ~(par & ctl))) == '0;
  endproperty
  a_and_off: assert property (p_and_off) else $error("AND channel on");

  property p_ot_off;
    (!sleep && !do_reset && ot_trip != '0) |=>
      (ot_off & $past(ot_trip)) == $past(ot_trip) ##1 (chan_on & $past(ot_trip, 2)) == '0;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("Hot channel stayed on");

  property p_ot_ignored;
    (s_sense.over_temp & ~chan_on & ~ot_off) != '0 |=>
      (ot_off & $past(s_sense.over_temp & ~chan_on & ~ot_off)) == '0;
  endproperty
  a_ot_ignored: assert property (p_ot_ignored) else $error("Off channel tripped");

  property p_ot_latch;
    (!sleep && !do_reset && (ot_off & ovt & ~eff_rise) != '0) |=>
      (ot_off & $past(ot_off & ovt & ~eff_rise)) == $past(ot_off & ovt & ~eff_rise);
  endproperty
  a_ot_latch: assert property (p_ot_latch) else $error("Latch released early");

  property p_fault_pin;
    diag_word != {FRAME_BITS{1'b1}} |=> fault_oe && !fault_out;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("Fault pin not pulled");

  sequence s_bad_frame;
    frame_end && !(frame_ok && cmd_valid(frame)) && !sleep;
  endsequence
  property p_reject;
    s_bad_frame |=> $stable(ctl) && $stable(map) && $stable(bol) && !$past(diag_clr);
  endproperty
  a_reject: assert property (p_reject) else $error("Rejected frame took effect");
endmodule
`default_nettype wire

// ### dv/osw_spi_master.sv
// SPI master model clocking 16-bit words into the switch as frames of nbits clocks
`timescale 1ns/1ps
`default_nettype none
module osw_spi_master (
  // Link pins
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  // Clock and data idle low, as the pull-downs leave them
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // Offset of 1.3 ns keeps the link clock off the core clock phase
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    #1.3;
    cs_n = 1'b0;
    #32;
    for (int i = nbits - 1; i >= 0; i--) begin
      si = (i < 16) ? tx[i] : 1'b0;
      sclk = 1'b1;
      #16;
      // SO moves after the rise, so take it just before the fall
      // Released SO reads as the inverse of the held level
      rx = {rx[14:0], so_oe ? so : ~so};
      sclk = 1'b0;
      #16;
    end
    si = 1'b0;
    #32;
    cs_n = 1'b1;
    #40;
  endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the octal switch serial control block
`timescale 1ns/1ps
`default_nettype none
module tb_top import osw_pkg::*;;
  logic core_clk, srst, rst_pin_n, pol, mpi, so, so_oe, fault_out, fault_oe;
  logic cs_n, sclk, si;
  logic [2:0] fpi;
  logic [7:0] chan_on, slew_slow;
  osw_sense_t sense;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [7:0] mr [1:7];
  logic [15:0] rx;

  osw_switch_ctrl #(.FILT_CYC(16), .OL_CYC(8)) u_dut (.core_clk(core_clk), .srst(srst),
    .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe), .rst_pin_n(rst_pin_n),
    .polarity_select_pin(pol), .fixed_parallel_inputs(fpi), .mappable_parallel_input(mpi),
    .sense(sense), .chan_on(chan_on), .slew_slow(slew_slow), .fault_out(fault_out),
    .fault_oe(fault_oe));
  osw_spi_master u_m (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));

  always #2 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic frame(input logic [15:0] tx, input int n);
    u_m.xfer(tx, n, rx);
    cyc(8);
  endtask

  task automatic mdef();
    for (int a = 1; a < 8; a++) mr[a] = (a == 1) ? MAP_RST : CFG_RST;
  endtask

  // Addresses 0 and 6 refuse writes, so the model keeps its value
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    frame({CMD_WRITE, 3'h0, a, d}, 16);
    if (a != 3'h0 && a != ADDR_STA) mr[a] = d;
  endtask

  function automatic logic [7:0] exp_on();
    logic [7:0] p;
    logic [3:0] lv;
    lv = {mpi, fpi} ^ {4{~pol}};
    for (int i = 0; i < 8; i++) p[i] = mr[1][i] ? lv[3] : (i < 3 ? lv[i] : 1'b0);
    return mr[2] & p & mr[7] | ~mr[2] & (p | mr[7]);
  endfunction

  task automatic rd(input logic [2:0] a);
    logic [7:0] e;
    e = (a == ADDR_STA) ? exp_on() : mr[a];
    frame({CMD_READ, 3'h0, a, 8'h00}, 16);
    frame(16'h0000, 16);
    chk(rx, {READ_PREFIX, a, e});
  endtask

  task automatic on_chk(input logic [7:0] e);
    cyc(6);
    chk({8'h00, chan_on}, {8'h00, e});
  endtask

  task automatic diag(input logic [15:0] e);
    frame(16'h0000, 16);
    chk(rx, e);
  endtask

  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    rst_pin_n = 1'b1;
    pol = 1'b1;
    mpi = 1'b0;
    fpi = 3'h0;
    sense = '0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    void'($urandom(32'h672C));
    cyc(4);
    mdef();
    chk({8'h00, chan_on}, 16'h0000);
    chk({15'h0, so_oe}, 16'h0000);
    for (int a = 1; a < 8; a++) rd(3'(a));
    diag(16'hFFFF);
    chk({15'h0, so_oe}, 16'h0000);
    $display("Test reset values done");

    for (int k = 0; k < 12; k++) begin
      pol = 1'($urandom);
      fpi = 3'($urandom);
      mpi = 1'($urandom);
      wr(ADDR_MAP, 8'($urandom) | 8'h08);
      wr(ADDR_BOL, 8'($urandom));
      wr(ADDR_CTL, 8'($urandom));
      wr(ADDR_SLE, 8'($urandom));
      on_chk(exp_on());
      chk({8'h00, slew_slow}, {8'h00, mr[5]});
    end
    rd(ADDR_STA);
    $display("Test channel logic done");

    // Short count refused, padded 24-clock frame keeps its last 16 bits
    frame({CMD_WRITE, 3'h0, ADDR_CTL, ~mr[7]}, 12);
    wr(3'h0, 8'hA5);
    wr(ADDR_STA, 8'h5A);
    on_chk(exp_on());
    mr[7] = ~mr[7];
    frame({CMD_WRITE, 3'h0, ADDR_CTL, mr[7]}, 24);
    on_chk(exp_on());
    frame({CMD_RESET, 14'h0000}, 16);
    mdef();
    rd(ADDR_MAP);
    $display("Test refusals done");

    pol = 1'b1;
    fpi = 3'h0;
    mpi = 1'b0;
    wr(ADDR_CTL, 8'h01);
    sense.over_temp = 8'hFE;
    on_chk(8'h01);
    chk({15'h0, fault_oe}, 16'h0000);
    sense.over_temp = 8'hFF;
    on_chk(8'h00);
    chk({14'h0, fault_oe, fault_out}, 16'h0002);
    sense.over_temp = 8'h00;
    on_chk(8'h01);
    diag(16'hFFFE);
    diag(16'hFFFF);
    wr(ADDR_OVT, 8'h01);
    sense.over_temp = 8'h01;
    cyc(6);
    sense.over_temp = 8'h00;
    on_chk(8'h00);
    diag(16'hFFFE);
    wr(ADDR_CTL, 8'h00);
    wr(ADDR_CTL, 8'h01);
    on_chk(8'h01);
    diag(16'hFFFF);
    $display("Test overtemperature done");

    wr(ADDR_OVL, 8'h01);
    sense.cur_limit = 8'h01;
    cyc(14);
    sense.cur_limit = 8'h00;
    on_chk(8'h00);
    frame(16'h0000, 12);
    diag(16'hFFFE);
    wr(ADDR_CTL, 8'h00);
    wr(ADDR_CTL, 8'h01);
    on_chk(8'h01);
    diag(16'hFFFF);
    wr(ADDR_OVL, 8'h00);
    sense.cur_limit = 8'h01;
    cyc(22);
    chk({8'h00, chan_on}, 16'h0001);
    chk({15'h0, fault_oe}, 16'h0001);
    sense.cur_limit = 8'h00;
    diag(16'hFFFE);
    // Off channels 1 and 2: open load and short to ground
    sense.open_load = 8'h02;
    sense.short_gnd = 8'h04;
    cyc(22);
    sense = '0;
    diag(16'hFFC7);
    $display("Test overload done");

    wr(ADDR_CTL, 8'hFF);
    fpi = 3'h1;
    rst_pin_n = 1'b0;
    on_chk(8'h00);
    rst_pin_n = 1'b1;
    mdef();
    on_chk(exp_on());
    diag(16'hFFFF);
    $display("Test sleep done");
    end_sim();
  end
endmodule
`default_nettype wire
